/* File: common/mdu_defs.vh */
// constants for the multiply/divide unit: register addresses, field positions, codes and counts
// assumes the special-function register port of an 8-bit core with 8-bit addresses
`ifndef MDU_DEFS_VH
`define MDU_DEFS_VH

// special-function register addresses
`define MDU_ADDR_BYTE0    8'hf9
`define MDU_ADDR_BYTE5    8'hfe
`define MDU_ADDR_ARITH    8'hff

// byte register indices, derived from the low address bits
`define MDU_IDX_BASE      3'h1
`define MDU_IDX_MD0       3'h0
`define MDU_IDX_MD1       3'h1
`define MDU_IDX_MD2       3'h2
`define MDU_IDX_MD3       3'h3
`define MDU_IDX_MD4       3'h4
`define MDU_IDX_MD5       3'h5

// arithmetic control register fields
`define MDU_ARC_SEQERR    7
`define MDU_ARC_OVF       6
`define MDU_ARC_DIR       5
`define MDU_ARC_SC_HI     4
`define MDU_ARC_SC_LO     0

// reset values
`define MDU_BYTE_RST      8'h00
`define MDU_SC_RST        5'h00
`define MDU_RDATA_IDLE    8'h00

// operation codes
`define MDU_OP_DIV32      3'h0
`define MDU_OP_DIV16      3'h1
`define MDU_OP_MUL        3'h2
`define MDU_OP_NORM       3'h3
`define MDU_OP_SHIFT      3'h4

// execution timing in system clock cycles
`define MDU_MUL_CYCLES    5'h0a
`define MDU_SHIFT_CYCLES  5'h03
`define MDU_DIV_STEPS32   5'h10
`define MDU_DIV_STEPS16   5'h08

`endif

/* File: verilog/mdu_shift.v */
// barrel shifter and leading-zero normaliser for the multiply/divide unit
// assumes a 32-bit operand held steady by the caller while the result is sampled
`timescale 1ns/1ps
`default_nettype none

module mdu_shift (
	// operand and control
	input  wire [31:0] opd,
	input  wire [4:0]  cnt,
	input  wire        dir_right,
	input  wire        norm,
	// results
	output reg  [31:0] res,
	output reg  [4:0]  lz,
	output reg         ovf
);

	integer i;

	// leading-zero count, then shift by it or by the given count
	always @* begin
		lz = 5'h00;
		for (i = 0; i < 32; i = i + 1) begin
			if (opd[i])
				lz = 5'h1f - i[4:0];
		end
		ovf = opd[31] | (opd == 32'h0000_0000);
		if (norm)
			res = ovf ? opd : (opd << lz);
		else if (dir_right)
			res = opd >> cnt;
		else
			res = opd << cnt;
	end

endmodule
`default_nettype wire

/* File: verilog/mdu_div.v */
// two-bits-per-cycle restoring divider, 32/16 or 16/16
// assumes a one-cycle start pulse with operands valid in that cycle
`timescale 1ns/1ps
`default_nettype none
`include "mdu_defs.vh"

module mdu_div (
	// clock and reset
	input  wire        mclk,
	input  wire        srst,
	// request
	input  wire        start,
	input  wire        wide,
	input  wire [31:0] dividend,
	input  wire [15:0] divisor,
	// answer
	output reg         done_r,
	output reg  [31:0] quo_r,
	output reg  [15:0] rem_r
);

	reg [15:0] dvs_r;
	reg [4:0]  steps_r;
	reg        run_r;
	reg [16:0] t;
	reg [15:0] r_nxt;
	reg [31:0] q_nxt;
	integer    k;

	// two shift-subtract steps per clock
	always @* begin
		r_nxt = rem_r;
		q_nxt = quo_r;
		t = 17'h0_0000;
		for (k = 0; k < 2; k = k + 1) begin
			t = {r_nxt, q_nxt[31]};
			q_nxt = {q_nxt[30:0], 1'b0};
			if (t >= {1'b0, dvs_r}) begin
				t = t - {1'b0, dvs_r};
				q_nxt[0] = 1'b1;
			end
			r_nxt = t[15:0];
		end
	end

	// operand capture and step counting; done pulses once
	always @(posedge mclk) begin
		if (srst) begin
			done_r  <= 1'b0;
			quo_r   <= 32'h0000_0000;
			rem_r   <= 16'h0000;
			dvs_r   <= 16'h0000;
			steps_r <= 5'h00;
			run_r   <= 1'b0;
		end else begin
			done_r <= 1'b0;
			if (start) begin
				quo_r   <= wide ? dividend : {dividend[15:0], 16'h0000};
				rem_r   <= 16'h0000;
				dvs_r   <= divisor;
				steps_r <= wide ? `MDU_DIV_STEPS32 : `MDU_DIV_STEPS16;
				run_r   <= 1'b1;
			end else if (run_r) begin
				quo_r   <= q_nxt;
				rem_r   <= r_nxt;
				steps_r <= steps_r - 5'h01;
				if (steps_r == 5'h01) begin
					run_r  <= 1'b0;
					done_r <= 1'b1;
				end
			end
		end
	end

endmodule
`default_nettype wire

/* File: verilog/mdu_top.v */
// multiply/divide unit: six operand bytes and an arithmetic control register on the core's register port
// assumes the core's register strobes are on mclk and last one cycle each
//
// How it works
// - load operands, execute, then read results back
// - byte0 write restarts sequencing and error window
// - 32-bit divide loads bytes 0-3, 16-bit divide bytes 0-1, then divisor 4,5
// - divisor high byte write starts division
// - quotient in bytes 0-3, remainder 4-5
// - last result read completes the operation
// - product lands in bytes 0-3
// - control write with zero count starts normalise
// - normalise removes leading zeros, count returned
// - control write with count, direction starts shift
// - error window: byte0 write to last read
// - out-of-order operand write sets sequence error
// - clean completed sequence clears sequence error
// - overflow: zero divisor, product overflow, normalised operand
// - multiply finishes in ten cycles
`timescale 1ns/1ps
`default_nettype none
`include "mdu_defs.vh"

module mdu_top (
	// clock and reset
	input  wire        mclk,
	input  wire        srst,
	// special-function register port
	input  wire [7:0]  sfr_addr,
	input  wire        sfr_wr,
	input  wire        sfr_rd,
	input  wire [7:0]  sfr_wdata,
	output reg  [7:0]  sfr_rdata_r,
	// status
	output reg         mdu_busy_r
);

	// load sequence states
	localparam LS_IDLE = 4'h0;
	localparam LS_M0   = 4'h1;
	localparam LS_D1   = 4'h2;
	localparam LS_D2   = 4'h3;
	localparam LS_D3   = 4'h4;
	localparam LS_D4L  = 4'h5;
	localparam LS_D4S  = 4'h6;
	localparam LS_MU4  = 4'h7;
	localparam LS_MU1  = 4'h8;

	// operation phases
	localparam PH_IDLE = 2'h0;
	localparam PH_LOAD = 2'h1;
	localparam PH_EXEC = 2'h2;
	localparam PH_READ = 2'h3;

	reg  [7:0]  md_r [0:5];
	reg  [4:0]  sc_r;
	reg         slr_r;
	reg         sequence_error_flag_r;
	reg         overflow_flag_r;
	reg         win_err_r;
	reg  [3:0]  ld_r;
	reg  [3:0]  ld_nxt;
	reg  [1:0]  ph_r;
	reg  [1:0]  ph_nxt;
	reg  [2:0]  op_r;
	reg  [2:0]  op_nxt;
	reg  [4:0]  cnt_r;
	reg  [2:0]  rstep_r;
	reg         go;
	reg         bad;
	reg         open;
	reg         adv;
	reg         acc_md;
	reg         acc_arc;
	reg         rd_adv;
	reg         fin;
	integer     n;

	wire        hit_md;
	wire        wr_md;
	wire        wr_arc;
	wire        rd_md;
	wire [2:0]  md_idx;
	wire [2:0]  exp_idx;
	wire        last_rd;
	wire        op_is_div;
	wire        exec_end;
	wire [31:0] opd32;
	wire [31:0] prod;
	wire [31:0] sh_res;
	wire [4:0]  sh_lz;
	wire        sh_ovf;
	wire        div_done;
	wire [31:0] div_quo;
	wire [15:0] div_rem;
	wire        div_start;

	// address decode
	assign hit_md = (sfr_addr >= `MDU_ADDR_BYTE0) && (sfr_addr <= `MDU_ADDR_BYTE5);
	assign md_idx = sfr_addr[2:0] - `MDU_IDX_BASE;
	assign wr_md  = sfr_wr & hit_md;
	assign rd_md  = sfr_rd & hit_md;
	assign wr_arc = sfr_wr & (sfr_addr == `MDU_ADDR_ARITH);

	// expected read order: short divide skips bytes 2 and 3
	assign op_is_div = (op_r == `MDU_OP_DIV32) || (op_r == `MDU_OP_DIV16);
	assign exp_idx   = ((op_r == `MDU_OP_DIV16) && (rstep_r >= `MDU_IDX_MD2)) ?
	                   (rstep_r + `MDU_IDX_MD2) : rstep_r;
	assign last_rd   = op_is_div ? (exp_idx == `MDU_IDX_MD5) : (exp_idx == `MDU_IDX_MD3);

	// arithmetic operands taken from the frozen byte registers
	assign opd32     = {md_r[3], md_r[2], md_r[1], md_r[0]};
	assign prod      = {md_r[1], md_r[0]} * {md_r[5], md_r[4]};
	assign exec_end  = op_is_div ? div_done : (cnt_r == 5'h00);
	assign div_start = go && ((op_nxt == `MDU_OP_DIV32) || (op_nxt == `MDU_OP_DIV16));

	// divider, fed with the divisor high byte as it is written
	mdu_div u_div (
		.mclk     (mclk),
		.srst     (srst),
		.start    (div_start),
		.wide     (op_nxt == `MDU_OP_DIV32),
		.dividend (opd32),
		.divisor  ({sfr_wdata, md_r[4]}),
		.done_r   (div_done),
		.quo_r    (div_quo),
		.rem_r    (div_rem)
	);

	// shifter and normaliser
	mdu_shift u_shift (
		.opd       (opd32),
		.cnt       (sc_r),
		.dir_right (slr_r),
		.norm      (op_r == `MDU_OP_NORM),
		.res       (sh_res),
		.lz        (sh_lz),
		.ovf       (sh_ovf)
	);

	// access sequencing: load order, start, read order and violations
	always @* begin
		ld_nxt  = ld_r;
		ph_nxt  = ph_r;
		op_nxt  = op_r;
		go      = 1'b0;
		bad     = 1'b0;
		open    = 1'b0;
		adv     = 1'b1;
		acc_md  = 1'b0;
		acc_arc = 1'b0;
		rd_adv  = 1'b0;
		fin     = 1'b0;
		if (wr_md && (md_idx == `MDU_IDX_MD0)) begin
			open   = 1'b1;
			acc_md = 1'b1;
			bad    = (ph_r != PH_IDLE);
			ld_nxt = LS_M0;
			ph_nxt = PH_LOAD;
		end else if (ph_r == PH_EXEC) begin
			bad = wr_md;
			if (exec_end)
				ph_nxt = PH_READ;
		end else if (wr_md) begin
			acc_md = 1'b1;
			case (ld_r)
				LS_M0: begin
					if (md_idx == `MDU_IDX_MD1)
						ld_nxt = LS_D1;
					else if (md_idx == `MDU_IDX_MD4)
						ld_nxt = LS_MU4;
					else
						adv = 1'b0;
				end
				LS_D1: begin
					if (md_idx == `MDU_IDX_MD2)
						ld_nxt = LS_D2;
					else if (md_idx == `MDU_IDX_MD4)
						ld_nxt = LS_D4S;
					else
						adv = 1'b0;
				end
				LS_D2: begin
					if (md_idx == `MDU_IDX_MD3)
						ld_nxt = LS_D3;
					else
						adv = 1'b0;
				end
				LS_D3: begin
					if (md_idx == `MDU_IDX_MD4)
						ld_nxt = LS_D4L;
					else
						adv = 1'b0;
				end
				LS_D4L: begin
					if (md_idx == `MDU_IDX_MD5) begin
						go     = 1'b1;
						op_nxt = `MDU_OP_DIV32;
					end else
						adv = 1'b0;
				end
				LS_D4S: begin
					if (md_idx == `MDU_IDX_MD5) begin
						go     = 1'b1;
						op_nxt = `MDU_OP_DIV16;
					end else
						adv = 1'b0;
				end
				LS_MU4: begin
					if (md_idx == `MDU_IDX_MD1)
						ld_nxt = LS_MU1;
					else
						adv = 1'b0;
				end
				LS_MU1: begin
					if (md_idx == `MDU_IDX_MD5) begin
						go     = 1'b1;
						op_nxt = `MDU_OP_MUL;
					end else
						adv = 1'b0;
				end
				default: adv = 1'b0;
			endcase
			if (!adv) begin
				bad    = (ph_r != PH_IDLE);
				ld_nxt = LS_IDLE;
				ph_nxt = PH_IDLE;
			end else if (go) begin
				ld_nxt = LS_IDLE;
				ph_nxt = PH_EXEC;
			end
		end else if (wr_arc) begin
			acc_arc = 1'b1;
			if (ld_r == LS_D3) begin
				go     = 1'b1;
				op_nxt = (sfr_wdata[`MDU_ARC_SC_HI:`MDU_ARC_SC_LO] == `MDU_SC_RST) ?
				         `MDU_OP_NORM : `MDU_OP_SHIFT;
				ld_nxt = LS_IDLE;
				ph_nxt = PH_EXEC;
			end else if (ph_r == PH_LOAD) begin
				bad    = 1'b1;
				ld_nxt = LS_IDLE;
				ph_nxt = PH_IDLE;
			end
		end else if (rd_md && (ph_r == PH_READ) && (md_idx == exp_idx)) begin
			rd_adv = 1'b1;
			if (last_rd) begin
				fin    = 1'b1;
				ph_nxt = PH_IDLE;
			end
		end
		// the execution phase accepts only a restart
		if ((ph_r == PH_EXEC) && !open)
			acc_arc = 1'b0;
	end

	// registers, execution and flags
	always @(posedge mclk) begin
		if (srst) begin
			for (n = 0; n < 6; n = n + 1)
				md_r[n] <= `MDU_BYTE_RST;
			sc_r        <= `MDU_SC_RST;
			slr_r       <= 1'b0;
			sequence_error_flag_r      <= 1'b0;
			overflow_flag_r      <= 1'b0;
			win_err_r   <= 1'b0;
			ld_r        <= LS_IDLE;
			ph_r        <= PH_IDLE;
			op_r        <= `MDU_OP_DIV32;
			cnt_r       <= 5'h00;
			rstep_r     <= 3'h0;
			sfr_rdata_r <= `MDU_RDATA_IDLE;
			mdu_busy_r  <= 1'b0;
		end else begin
			ld_r       <= ld_nxt;
			ph_r       <= ph_nxt;
			op_r       <= op_nxt;
			mdu_busy_r <= (ph_nxt == PH_EXEC);
			if (acc_md)
				md_r[md_idx] <= sfr_wdata;
			if (acc_arc) begin
				sc_r  <= sfr_wdata[`MDU_ARC_SC_HI:`MDU_ARC_SC_LO];
				slr_r <= sfr_wdata[`MDU_ARC_DIR];
			end
			// start: clear overflow, load fixed latency, rewind read order
			if (go) begin
				overflow_flag_r  <= 1'b0;
				rstep_r <= 3'h0;
				cnt_r   <= (op_nxt == `MDU_OP_MUL) ? (`MDU_MUL_CYCLES - 5'h01) :
				           (`MDU_SHIFT_CYCLES - 5'h01);
			end else if ((ph_r == PH_EXEC) && (cnt_r != 5'h00))
				cnt_r <= cnt_r - 5'h01;
			// result write-back at the end of execution
			if ((ph_r == PH_EXEC) && exec_end && !open) begin
				case (op_r)
					`MDU_OP_DIV32, `MDU_OP_DIV16: begin
						{md_r[3], md_r[2], md_r[1], md_r[0]} <= div_quo;
						{md_r[5], md_r[4]} <= div_rem;
						overflow_flag_r <= ({md_r[5], md_r[4]} == 16'h0000);
					end
					`MDU_OP_MUL: begin
						{md_r[3], md_r[2], md_r[1], md_r[0]} <= prod;
						overflow_flag_r <= (prod[31:16] != 16'h0000);
					end
					`MDU_OP_NORM: begin
						{md_r[3], md_r[2], md_r[1], md_r[0]} <= sh_res;
						sc_r   <= sh_ovf ? `MDU_SC_RST : sh_lz;
						overflow_flag_r <= sh_ovf;
					end
					default: begin
						{md_r[3], md_r[2], md_r[1], md_r[0]} <= sh_res;
					end
				endcase
			end
			if (rd_adv)
				rstep_r <= rstep_r + 3'h1;
			// error window opens on byte0, closes on the last read
			if (open)
				win_err_r <= 1'b0;
			else if (bad)
				win_err_r <= 1'b1;
			if (bad)
				sequence_error_flag_r <= 1'b1;
			else if (fin && !win_err_r)
				sequence_error_flag_r <= 1'b0;
			// read data
			if (sfr_rd) begin
				if (hit_md)
					sfr_rdata_r <= md_r[md_idx];
				else if (sfr_addr == `MDU_ADDR_ARITH)
					sfr_rdata_r <= {sequence_error_flag_r, overflow_flag_r, slr_r, sc_r};
				else
					sfr_rdata_r <= `MDU_RDATA_IDLE;
			end
		end
	end

endmodule
`default_nettype wire

/* File: tb/mdu_top_monitor.sv */
// checker for the multiply/divide unit: busy spans and read-port behaviour
// assumes binding onto mdu_top, one mclk domain, srst synchronous
`timescale 1ns/1ps
`default_nettype none
module mdu_top_monitor (
	// clock and reset
	input wire logic       mclk,
	input wire logic       srst,
	// register port
	input wire logic [7:0] sfr_addr,
	input wire logic       sfr_wr,
	input wire logic       sfr_rd,
	input wire logic [7:0] sfr_wdata,
	input wire logic [7:0] sfr_rdata_r,
	input wire logic       mdu_busy_r
);
	logic [7:0] last_wr_r;
	logic [4:0] busy_cnt_r;
	// last written address and length of the current busy run
	always @(posedge mclk) begin
		if (srst) begin
			last_wr_r <= 8'h00;
			busy_cnt_r <= 5'h00;
		end else begin
			last_wr_r <= sfr_wr ? sfr_addr : last_wr_r;
			busy_cnt_r <= mdu_busy_r ? busy_cnt_r + 5'h01 : 5'h00;
		end
	end
	a_mul_busy_ten: assert property (@(posedge mclk) disable iff (srst)
		sfr_wr && sfr_addr == 8'hfe && last_wr_r == 8'hfa && !mdu_busy_r
		|=> mdu_busy_r [*8] ##1 mdu_busy_r [*2] ##1 !mdu_busy_r) else $error("multiply busy span wrong");
	a_shift_busy_three: assert property (@(posedge mclk) disable iff (srst)
		sfr_wr && sfr_addr == 8'hff && last_wr_r == 8'hfc && !mdu_busy_r
		|=> mdu_busy_r [*3] ##1 !mdu_busy_r) else $error("shift busy span wrong");
	a_div_start_bounded: assert property (@(posedge mclk) disable iff (srst)
		sfr_wr && sfr_addr == 8'hfe && last_wr_r == 8'hfd && !mdu_busy_r
		|=> mdu_busy_r ##[6:19] !mdu_busy_r) else $error("divide busy span wrong");
	a_rdata_holds: assert property (@(posedge mclk) disable iff (srst)
		!sfr_rd |=> $stable(sfr_rdata_r)) else $error("read data moved without a read");
	a_unmapped_zero: assert property (@(posedge mclk) disable iff (srst)
		sfr_rd && sfr_addr < 8'hf9 |=> sfr_rdata_r == 8'h00) else $error("unmapped read not zero");
	a_reset_idle: assert property (@(posedge mclk)
		srst |=> !mdu_busy_r && sfr_rdata_r == 8'h00) else $error("reset left unit active");
	a_busy_has_cause: assert property (@(posedge mclk) disable iff (srst)
		$rose(mdu_busy_r) |-> $past(sfr_wr) && $past(sfr_addr) >= 8'hfe) else $error("busy without start write");
	a_busy_bounded: assert property (@(posedge mclk) disable iff (srst)
		busy_cnt_r <= 5'd20) else $error("execution too long");
	a_restart_idles: assert property (@(posedge mclk) disable iff (srst)
		sfr_wr && sfr_addr == 8'hf9 |=> !mdu_busy_r) else $error("byte0 write left unit busy");
endmodule
bind mdu_top mdu_top_monitor mdu_top_monitor_i (.mclk(mclk), .srst(srst), .sfr_addr(sfr_addr),
	.sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata_r(sfr_rdata_r), .mdu_busy_r(mdu_busy_r));
`default_nettype wire

/* File: tb/mdu_core_model.sv */
// processor core model: one-cycle register strobes after an optional stall
// assumes the unit takes strobes on rising mclk
`timescale 1ns/1ps
`default_nettype none
module mdu_core_model (
	// clock
	input  wire logic       mclk,
	// register port
	output var  logic [7:0] sfr_addr,
	output var  logic       sfr_wr,
	output var  logic       sfr_rd,
	output var  logic [7:0] sfr_wdata,
	input  wire logic [7:0] sfr_rdata_r
);
	int gap = 0;
	// idle port
	initial begin
		sfr_addr = 8'h00;
		sfr_wr = 1'b0;
		sfr_rd = 1'b0;
		sfr_wdata = 8'h00;
	end
	// one write, released address shows its inverse
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		repeat (gap) @(posedge mclk);
		@(posedge mclk);
		#1;
		sfr_addr = a;
		sfr_wdata = d;
		sfr_wr = 1'b1;
		@(posedge mclk);
		#1;
		sfr_wr = 1'b0;
		sfr_addr = ~a;
		sfr_wdata = ~d;
	endtask
	// one read, data taken after the taking edge
	task automatic rd(input logic [7:0] a, output logic [7:0] q);
		repeat (gap) @(posedge mclk);
		@(posedge mclk);
		#1;
		sfr_addr = a;
		sfr_rd = 1'b1;
		@(posedge mclk);
		#1;
		sfr_rd = 1'b0;
		sfr_addr = ~a;
		q = sfr_rdata_r;
	endtask
endmodule
`default_nettype wire

/* File: tb/mdu_top_bench.sv */
// self-checking bench for the multiply/divide unit
// assumes mdu_top and the core model driving its register port
`timescale 1ns/1ps
`default_nettype none
module mdu_top_bench;
	logic mclk = 1'b0;
	logic srst = 1'b1;
	logic [7:0] sfr_addr, sfr_wdata, sfr_rdata_r;
	logic sfr_wr, sfr_rd, mdu_busy_r;
	int failures = 0;
	int n_tests = 0;
	always #12.5 mclk = ~mclk;
	mdu_top mdu_top_i (.mclk(mclk), .srst(srst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
		.sfr_wdata(sfr_wdata), .sfr_rdata_r(sfr_rdata_r), .mdu_busy_r(mdu_busy_r));
	mdu_core_model mdu_core_model_i (.mclk(mclk), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
		.sfr_wdata(sfr_wdata), .sfr_rdata_r(sfr_rdata_r));
	// compare and count
	task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
		n_tests++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic test_done;
		$display("checks=%0d failures=%0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// byte register i at f9+i, control at i=6
	task automatic w(input int i, input logic [7:0] d);
		mdu_core_model_i.wr(8'hf9 + 8'(i), d);
	endtask
	task automatic r(input int i, output logic [7:0] q);
		mdu_core_model_i.rd(8'hf9 + 8'(i), q);
	endtask
	// k: 0 div32, 1 div16, 2 mul, 3 norm, 4 shift; bad adds a write while busy
	task automatic op(input int k, input logic [31:0] a, input logic [15:0] b, input logic [5:0] c, input bit bad);
		logic [47:0] ex;
		logic [31:0] d;
		logic [7:0] v;
		int lz, n;
		bit ov;
		ov = 0;
		lz = 0;
		n = 0;
		d = (k == 1) ? {16'h0000, a[15:0]} : a;
		ex = {16'h0000, d};
		if (k < 2 && b == 0)
			ov = 1;
		else if (k < 2)
			ex = {16'(d % b), d / b};
		if (k == 2)
			ex = 48'(a[15:0]) * 48'(b); // full 32-bit product, no self-sized truncation
		if (k == 2)
			ov = ex[31:16] != 0;
		if (k == 3 && (a == 0 || a[31]))
			ov = 1;
		while (k == 3 && !ov && !ex[31]) begin
			ex = ex << 1;
			lz++;
		end
		if (k == 4)
			ex = {16'h0000, c[5] ? a >> c[4:0] : a << c[4:0]};
		w(0, a[7:0]);
		if (k == 2) begin
			w(4, b[7:0]);
			w(1, a[15:8]);
			w(5, b[15:8]);
		end else begin
			w(1, a[15:8]);
			if (k != 1)
				w(2, a[23:16]);
			if (k != 1)
				w(3, a[31:24]);
			if (k < 2)
				w(4, b[7:0]);
			w(k < 2 ? 5 : 6, k < 2 ? b[15:8] : {2'b00, c});
		end
		if (bad)
			w(2, 8'h5a);
		while (mdu_busy_r !== 1'b0 && n < 40) begin
			@(posedge mclk);
			#1;
			n++;
		end
		if (n == 40)
			chk(48'h1, 48'h0);
		for (int i = 0; i < 6; i++) begin
			if ((i < 2) || (i < 4 && k != 1) || (i > 3 && k < 2)) begin
				r(i, v);
				if (!(k < 2 && b == 0))
					chk(v, ex[8*i +: 8]);
			end
		end
		r(6, v);
		chk(v[7:6], {bad, ov});
		if (k > 2)
			chk(v[5:0], k == 3 ? 6'(lz) : c);
	endtask
	// watchdog
	initial begin
		#2_000_000;
		failures++;
		test_done;
	end
	initial begin
		logic [7:0] v;
		int s;
		s = $urandom(32'heb95b635);
		repeat (20) @(posedge mclk);
		#1;
		srst = 1'b0;
		for (int i = 0; i < 7; i++) begin
			r(i, v);
			chk(v, 48'h0);
		end
		mdu_core_model_i.rd(8'h10, v);
		chk(v, 48'h0);
		// restart a multiply load with byte0: flag set, then a clean run clears it
		w(0, 8'h11);
		w(4, 8'h22);
		w(0, 8'h33);
		r(6, v);
		chk(v[7], 1'b1);
		op(2, 32'h0000_0003, 16'h0005, 6'h00, 0);
		for (int j = 0; j < 6; j++) begin
			mdu_core_model_i.gap = $urandom_range(2);
			op(0, $urandom, 16'($urandom_range(16'hffff, 1)), 6'h00, 0);
			op(1, $urandom, 16'($urandom_range(16'hffff, 1)), 6'h00, 0);
			op(2, $urandom, 16'($urandom), 6'h00, j == 2);
			op(3, $urandom >> (j * 5), 16'h0000, 6'h00, 0);
		end
		op(0, 32'h1234_5678, 16'h0000, 6'h00, 0);
		op(2, 32'h0000_ffff, 16'hffff, 6'h00, 0);
		op(3, 32'h0000_0000, 16'h0000, 6'h00, 0);
		op(3, 32'h8000_0001, 16'h0000, 6'h00, 0);
		op(3, 32'h0000_0001, 16'h0000, 6'h00, 0);
		for (int c = 1; c < 32; c++)
			op(4, $urandom, 16'h0000, {c[0], 5'(c)}, 0);
		w(0, 8'ha5);
		@(posedge mclk);
		#1;
		srst = 1'b1;
		@(posedge mclk);
		#1;
		srst = 1'b0;
		r(0, v);
		chk(v, 48'h0);
		test_done;
	end
endmodule
`default_nettype wire
